// [design/fmpg_map.svh]
`ifndef FMPG_MAP_SVH
`define FMPG_MAP_SVH

// register offsets on the two-wire host port
`define FMPG_OFS_RAIL_FAULT_MASK_B   8'ha3
`define FMPG_OFS_OUTPUT1_PG_SELECT_A 8'ha4
`define FMPG_OFS_OUTPUT1_PG_SELECT_B 8'ha5

// factory option values (one variant as default)
`define FMPG_RST_RAIL_FAULT_MASK_B   8'h27
`define FMPG_RST_OUTPUT1_PG_SELECT_A 8'hfd
`define FMPG_RST_OUTPUT1_PG_SELECT_B 8'hff

// fault-mask field positions
`define FMPG_FM_RO_BIT         7
`define FMPG_FM_AUX_LDO1       4
`define FMPG_FM_TERMINATION    3
`define FMPG_FM_SWITCH_B2      2
`define FMPG_FM_SWITCH_B1      1
`define FMPG_FM_AUX_LDO3       0

// serial framing
`define FMPG_BYTE_LAST_BIT     4'h7
`define FMPG_BYTE_BITS         4'h8
`define FMPG_UNMAPPED_READ     8'h00
`define FMPG_SYNC_RESET        6'h03
`define FMPG_DEV_ADDR_DEFAULT  7'h5e

`endif

// [design/fmpg_pkg.sv]
package fmpg_pkg;

    typedef enum logic [2:0] {
        FMPG_IDLE      = 3'b000,
        FMPG_ADDR      = 3'b001,
        FMPG_ACK_ADDR  = 3'b010,
        FMPG_PTR       = 3'b011,
        FMPG_ACK_BYTE  = 3'b100,
        FMPG_WDATA     = 3'b101,
        FMPG_RDATA     = 3'b110,
        FMPG_RACK      = 3'b111
    } fmpg_state_e;

    typedef logic [7:0] fmpg_byte_t;

endpackage

// [design/fmpg_tree.sv]
`timescale 1ns/100ps
`default_nettype none

module fmpg_tree
    import fmpg_pkg::*;
#(
    parameter int NUM_BUCK = 6
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    // register fields
    input  wire logic [4:0]         faultMask,
    input  wire fmpg_byte_t         selectA,
    input  wire fmpg_byte_t         selectB,
    // rail status
    input  wire logic [4:0]         railFault,
    input  wire logic [NUM_BUCK-1:0] buckPg,
    input  wire logic               auxLdo2Pg,
    input  wire logic               switchA1Pg,
    input  wire logic [3:0]         ctrlIn,
    input  wire logic               terminationPg,
    input  wire logic               sharedRailPg,
    input  wire logic               switchB1Pg,
    input  wire logic               auxLdo3Pg,
    // results
    output logic                    generalOutputOne,
    output logic                    shutdownRequest
);

    if (NUM_BUCK != 6) begin : g_bad_buck
        $error("fmpg_tree serves exactly six buck rails");
    end

    wire logic [4:0] faultLive;
    wire logic [5:0] buckPass;
    wire logic [1:0] upperPass;
    wire logic [3:0] ctrlPass;
    wire logic       termPass;
    wire logic       sharedPass;
    wire logic       swB1Pass;
    wire logic       ldo3Pass;
    wire logic       treeGood;

    // a masked fault is dropped before the shutdown vote
    genvar i;
    for (i = 0; i < 5; i++) begin : g_fault
        assign faultLive[i] = railFault[i] & ~faultMask[i]; // R03 R04 R05 R06 R07
    end

    assign upperPass  = {auxLdo2Pg, switchA1Pg} | selectA[7:6]; // R08 R09
    assign buckPass   = buckPg | selectA[5:0];                 // R10
    assign ctrlPass   = ctrlIn | selectB[7:4];                 // R11
    assign termPass   = terminationPg | selectB[3];            // R12
    assign sharedPass = sharedRailPg | selectB[2];             // R13
    assign swB1Pass   = switchB1Pg | selectB[1];               // R14
    assign ldo3Pass   = auxLdo3Pg | selectB[0];                // R15

    // ignored sources pass as good, so they cannot pull the pin low
    assign treeGood = &{upperPass, buckPass, ctrlPass, termPass,
                        sharedPass, swB1Pass, ldo3Pass};       // R17

    always_ff @(posedge core_clk) begin
        if (reset) begin
            generalOutputOne <= 1'b0;
            shutdownRequest  <= 1'b0;
        end else begin
            generalOutputOne <= treeGood;    // R17
            shutdownRequest  <= |faultLive;  // R03 R04 R05 R06 R07
        end
    end

endmodule // fmpg_tree

`default_nettype wire

// [design/fmpg_regs.sv]
// Operation
// R01 - host writes zero into fault-mask-b reserved bit 6.
// R02 - host writes one into fault-mask-b reserved bit 5.
// R03 - fault-mask-b bit 4 set stops aux LDO one faults causing shutdown.
// R04 - fault-mask-b bit 3 set stops termination regulator faults causing shutdown.
// R05 - fault-mask-b bit 2 set stops load switch B two faults causing shutdown.
// R06 - fault-mask-b bit 1 set stops load switch B one faults causing shutdown.
// R07 - fault-mask-b bit 0 set stops aux LDO three faults causing shutdown.
// R08 - select-a bit 7 clear includes aux LDO two power-good in output one.
// R09 - select-a bit 6 clear includes load switch A one power-good.
// R10 - select-a bits 5..0 clear include buck six..one power-good.
// R11 - select-b bits 7..4 clear include control inputs five, four, two, one.
// R12 - select-b bit 3 clear includes termination regulator power-good.
// R13 - select-b bit 2 clear includes shared switch/LDO rail power-good.
// R14 - select-b bit 1 clear includes load switch B one power-good.
// R15 - select-b bit 0 clear includes aux LDO three power-good.
// R16 - reset loads all three registers from factory option values.
// R17 - output one is good only when every included source is good.
// R18 - fault-mask-b bit 7 is read-only, returning its factory value.
`include "fmpg_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fmpg_regs
    import fmpg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR     = `FMPG_DEV_ADDR_DEFAULT, // arbitrary value
    parameter fmpg_byte_t FAULT_MASK_B = `FMPG_RST_RAIL_FAULT_MASK_B,
    parameter fmpg_byte_t SELECT_A     = `FMPG_RST_OUTPUT1_PG_SELECT_A,
    parameter fmpg_byte_t SELECT_B     = `FMPG_RST_OUTPUT1_PG_SELECT_B
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // two-wire host port
    input  wire logic        sclPin,
    input  wire logic        sdaPin,
    output logic             sdaOut,
    output logic             sdaOe,
    // control input pins five, four, two, one
    input  wire logic [3:0]  ctrlPin,
    // rail power-good
    input  wire logic [5:0]  buckPg,
    input  wire logic        auxLdo2Pg,
    input  wire logic        switchA1Pg,
    input  wire logic        terminationPg,
    input  wire logic        sharedRailPg,
    input  wire logic        switchB1Pg,
    input  wire logic        auxLdo3Pg,
    // rail faults
    input  wire logic        auxLdo1Fault,
    input  wire logic        terminationFault,
    input  wire logic        switchB2Fault,
    input  wire logic        switchB1Fault,
    input  wire logic        auxLdo3Fault,
    // results
    output logic             generalOutputOne,
    output logic             shutdownRequest
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire logic [5:0] pinRaw;
    logic      [5:0] syncA;
    logic      [5:0] syncB;
    logic      [5:0] syncC;
    logic      [5:0] pinStable;

    assign pinRaw = {ctrlPin, sdaPin, sclPin};

    // a change is only taken once stages two and three agree
    genvar g;
    for (g = 0; g < 6; g++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (reset) begin
                syncA[g]     <= 1'(`FMPG_SYNC_RESET >> g);
                syncB[g]     <= 1'(`FMPG_SYNC_RESET >> g);
                syncC[g]     <= 1'(`FMPG_SYNC_RESET >> g);
                pinStable[g] <= 1'(`FMPG_SYNC_RESET >> g);
            end else begin
                syncA[g] <= pinRaw[g];
                syncB[g] <= syncA[g];
                syncC[g] <= syncB[g];
                if (syncB[g] == syncC[g]) begin
                    pinStable[g] <= syncC[g];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    logic       sclPrev;
    logic       sdaPrev;
    wire  logic sclNow;
    wire  logic sdaNow;
    wire  logic sclRise;
    wire  logic sclFall;
    wire  logic startSeen;
    wire  logic stopSeen;

    assign sclNow    = pinStable[0];
    assign sdaNow    = pinStable[1];
    assign sclRise   = sclNow & ~sclPrev;
    assign sclFall   = ~sclNow & sclPrev;
    assign startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
    assign stopSeen  = sclNow & sclPrev & ~sdaPrev & sdaNow;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclNow;
            sdaPrev <= sdaNow;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    fmpg_byte_t railFaultMaskB;
    fmpg_byte_t output1PgSelectA;
    fmpg_byte_t output1PgSelectB;
    fmpg_byte_t regPtr;
    fmpg_byte_t shiftReg;
    logic       writeStrobe;

    // unmapped offsets read as zero and swallow writes
    function automatic fmpg_byte_t regRead(input fmpg_byte_t ofs,
                                           input fmpg_byte_t fm,
                                           input fmpg_byte_t sa,
                                           input fmpg_byte_t sb);
        case (ofs)
            `FMPG_OFS_RAIL_FAULT_MASK_B:   regRead = fm;
            `FMPG_OFS_OUTPUT1_PG_SELECT_A: regRead = sa;
            `FMPG_OFS_OUTPUT1_PG_SELECT_B: regRead = sb;
            default:                       regRead = `FMPG_UNMAPPED_READ;
        endcase
    endfunction

    wire fmpg_byte_t readData;
    wire logic       hitFault;
    wire logic       hitSelA;
    wire logic       hitSelB;
    wire fmpg_byte_t next_faultMaskB;

    assign readData = regRead(regPtr, railFaultMaskB, output1PgSelectA, output1PgSelectB);
    assign hitFault = writeStrobe & (regPtr == `FMPG_OFS_RAIL_FAULT_MASK_B);
    assign hitSelA  = writeStrobe & (regPtr == `FMPG_OFS_OUTPUT1_PG_SELECT_A);
    assign hitSelB  = writeStrobe & (regPtr == `FMPG_OFS_OUTPUT1_PG_SELECT_B);

    // top bit keeps its factory value whatever the host writes
    assign next_faultMaskB = {FAULT_MASK_B[`FMPG_FM_RO_BIT],
                              shiftReg[`FMPG_FM_RO_BIT-1:0]};   // R18

    always_ff @(posedge core_clk) begin
        if (reset) begin
            railFaultMaskB   <= FAULT_MASK_B;   // R16
            output1PgSelectA <= SELECT_A;       // R16
            output1PgSelectB <= SELECT_B;       // R16
        end else begin
            if (hitFault) begin
                railFaultMaskB <= next_faultMaskB; // R18
            end
            if (hitSelA) begin
                output1PgSelectA <= shiftReg;
            end
            if (hitSelB) begin
                output1PgSelectB <= shiftReg;
            end
        end
    end

    // ------------------------------------------------------------
    // serial target
    // ------------------------------------------------------------
    fmpg_state_e state;
    logic [3:0]  bitCnt;
    logic        readMode;
    logic        hostAck;
    wire  logic  byteDone;
    wire  logic  addrMatch;

    assign byteDone  = sclFall & (bitCnt == `FMPG_BYTE_BITS);
    assign addrMatch = (shiftReg[7:1] == DEV_ADDR);

    // sda only ever changes while scl is low, so no false start or stop
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state       <= FMPG_IDLE;
            bitCnt      <= 4'h0;
            readMode    <= 1'b0;
            hostAck     <= 1'b0;
            regPtr      <= 8'h00;
            shiftReg    <= 8'h00;
            sdaOe       <= 1'b0;
            sdaOut      <= 1'b0;
            writeStrobe <= 1'b0;
        end else begin
            writeStrobe <= 1'b0;
            sdaOut      <= 1'b0;
            if (startSeen) begin
                state  <= FMPG_ADDR;
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
            end else if (stopSeen) begin
                state <= FMPG_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    FMPG_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    FMPG_ADDR, FMPG_PTR, FMPG_WDATA: begin
                        if (sclRise) begin
                            shiftReg <= {shiftReg[6:0], sdaNow};
                            bitCnt   <= bitCnt + 4'h1;
                        end else if (byteDone) begin
                            bitCnt <= 4'h0;
                            if (state == FMPG_ADDR) begin
                                if (addrMatch) begin
                                    readMode <= shiftReg[0];
                                    sdaOe    <= 1'b1;
                                    state    <= FMPG_ACK_ADDR;
                                end else begin
                                    state <= FMPG_IDLE;
                                end
                            end else if (state == FMPG_PTR) begin
                                regPtr <= shiftReg;
                                sdaOe  <= 1'b1;
                                state  <= FMPG_ACK_BYTE;
                            end else begin
                                writeStrobe <= 1'b1;
                                sdaOe       <= 1'b1;
                                state       <= FMPG_ACK_BYTE;
                            end
                        end
                    end
                    FMPG_ACK_ADDR: begin
                        if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (readMode) begin
                                shiftReg <= readData;
                                sdaOe    <= ~readData[7];
                                state    <= FMPG_RDATA;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= FMPG_PTR;
                            end
                        end
                    end
                    FMPG_ACK_BYTE: begin
                        // pointer steps after a data byte, never after the pointer byte
                        if (writeStrobe) begin
                            regPtr <= regPtr + 8'h01;
                        end
                        if (sclFall) begin
                            sdaOe  <= 1'b0;
                            bitCnt <= 4'h0;
                            state  <= FMPG_WDATA;
                        end
                    end
                    FMPG_RDATA: begin
                        if (sclFall) begin
                            if (bitCnt == `FMPG_BYTE_LAST_BIT) begin
                                sdaOe  <= 1'b0;
                                regPtr <= regPtr + 8'h01;
                                state  <= FMPG_RACK;
                            end else begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                sdaOe    <= ~shiftReg[6];
                                bitCnt   <= bitCnt + 4'h1;
                            end
                        end
                    end
                    FMPG_RACK: begin
                        if (sclRise) begin
                            hostAck <= ~sdaNow;
                        end else if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (hostAck) begin
                                shiftReg <= readData;
                                sdaOe    <= ~readData[7];
                                state    <= FMPG_RDATA;
                            end else begin
                                state <= FMPG_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= FMPG_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // fault gate and power-good tree
    // ------------------------------------------------------------
    wire logic [4:0] railFault;
    wire logic [4:0] faultMaskField;

    assign railFault = {auxLdo1Fault, terminationFault, switchB2Fault,
                        switchB1Fault, auxLdo3Fault};
    assign faultMaskField = {railFaultMaskB[`FMPG_FM_AUX_LDO1],
                             railFaultMaskB[`FMPG_FM_TERMINATION],
                             railFaultMaskB[`FMPG_FM_SWITCH_B2],
                             railFaultMaskB[`FMPG_FM_SWITCH_B1],
                             railFaultMaskB[`FMPG_FM_AUX_LDO3]};

    fmpg_tree #(
        .NUM_BUCK (6)
    ) u_tree (
        .core_clk         (core_clk),
        .reset            (reset),
        .faultMask        (faultMaskField),
        .selectA          (output1PgSelectA),
        .selectB          (output1PgSelectB),
        .railFault        (railFault),
        .buckPg           (buckPg),
        .auxLdo2Pg        (auxLdo2Pg),
        .switchA1Pg       (switchA1Pg),
        .ctrlIn           (pinStable[5:2]),
        .terminationPg    (terminationPg),
        .sharedRailPg     (sharedRailPg),
        .switchB1Pg       (switchB1Pg),
        .auxLdo3Pg        (auxLdo3Pg),
        .generalOutputOne (generalOutputOne),
        .shutdownRequest  (shutdownRequest)
    );

endmodule // fmpg_regs

`default_nettype wire

// [dv/fmpg_regs_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------
// port checker
// ------------
module fmpg_regs_properties (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // two-wire host port
    input  wire logic       sclPin,
    input  wire logic       sdaOe,
    // rail status
    input  wire logic [3:0] ctrlPin,
    input  wire logic [5:0] buckPg,
    input  wire logic       auxLdo2Pg,
    input  wire logic       switchA1Pg,
    input  wire logic       terminationPg,
    input  wire logic       sharedRailPg,
    input  wire logic       switchB1Pg,
    input  wire logic       auxLdo3Pg,
    input  wire logic       auxLdo1Fault,
    input  wire logic       terminationFault,
    input  wire logic       switchB2Fault,
    input  wire logic       switchB1Fault,
    input  wire logic       auxLdo3Fault,
    // results
    input  wire logic       generalOutputOne,
    input  wire logic       shutdownRequest
);
    wire logic [15:0] srcVec = {auxLdo2Pg, switchA1Pg, buckPg, ctrlPin, terminationPg,
                                sharedRailPg, switchB1Pg, auxLdo3Pg};
    wire logic [4:0]  faultVec = {auxLdo1Fault, terminationFault, switchB2Fault,
                                  switchB1Fault, auxLdo3Fault};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // watched during reset too, so no disable
    reset_quiet_a: assert property (disable iff (1'b0) reset |=>
        !generalOutputOne && !shutdownRequest && !sdaOe) else $error("outputs busy in reset");
    quiet_rails_a: assert property (faultVec == 5'h00 |=> !shutdownRequest)
        else $error("shutdown with no fault");
    shutdown_cause_a: assert property ($rose(shutdownRequest) |-> $past(faultVec) != 5'h00)
        else $error("shutdown rose without fault");
    // eight quiet cycles cover a late register update after the last scl fall
    fault_steady_a: assert property ((sclPin && $stable(faultVec))[*8] |=>
        $stable(shutdownRequest)) else $error("shutdown moved while inputs still");
    all_good_a: assert property ((&srcVec)[*8] |=> generalOutputOne)
        else $error("output one low with all sources good");
    tree_steady_a: assert property ((sclPin && $stable(srcVec))[*8] |=>
        $stable(generalOutputOne)) else $error("output one moved while inputs still");
    oe_low_phase_a: assert property ($changed(sdaOe) |-> !sclPin && !$past(sclPin, 3))
        else $error("data drive changed with clock high");
    oe_release_a: assert property ($rose(sdaOe) |-> ##[1:400] !sdaOe)
        else $error("data line held too long");
endmodule // fmpg_regs_properties
bind fmpg_regs fmpg_regs_properties u_props (
    .core_clk, .reset, .sclPin, .sdaOe, .ctrlPin, .buckPg, .auxLdo2Pg, .switchA1Pg,
    .terminationPg, .sharedRailPg, .switchB1Pg, .auxLdo3Pg, .auxLdo1Fault,
    .terminationFault, .switchB2Fault, .switchB1Fault, .auxLdo3Fault,
    .generalOutputOne, .shutdownRequest
);
`default_nettype wire

// [dv/fmpg_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------
// two-wire host model
// ------------
module fmpg_host
    import fmpg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h5e // arbitrary value
) (
    // clock
    input  wire logic core_clk,
    // bus pins
    output var  logic sclPin,
    output wire logic sdaPin,
    input  wire logic sdaOut,
    input  wire logic sdaOe
);
    logic hostSda = 1'b1;
    int   half    = 10; // cycles per scl phase, raise for a slow host
    // pull-up: a released line reads high, never a stale level
    assign sdaPin = hostSda & ~(sdaOe & ~sdaOut);
    initial sclPin = 1'b1;
    task automatic hcyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic bit_clk(input logic b, output logic s);
        hostSda = b;
        hcyc(half / 2);
        sclPin = 1'b1;
        hcyc(half / 2);
        s = sdaPin;
        hcyc(half / 2);
        sclPin = 1'b0;
        hcyc(half / 2);
    endtask
    task automatic start_cond();
        hostSda = 1'b1;
        hcyc(half / 2);
        sclPin = 1'b1;
        hcyc(half);
        hostSda = 1'b0;
        hcyc(half);
        sclPin = 1'b0;
        hcyc(half / 2);
    endtask
    task automatic stop_cond();
        hostSda = 1'b0;
        hcyc(half / 2);
        sclPin = 1'b1;
        hcyc(half);
        hostSda = 1'b1;
        hcyc(half);
    endtask
    // eight bits msb first, ninth clock released for the answer
    task automatic send_byte(input fmpg_byte_t d, output logic ack);
        logic [8:0] v;
        logic [8:0] s;
        v = {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            bit_clk(v[i], s[i]);
        end
        ack = ~s[0];
    endtask
    task automatic write_reg(input logic [6:0] dev, input fmpg_byte_t p, input fmpg_byte_t d0,
                             input fmpg_byte_t d1, input logic two, output logic ok);
        logic [3:0] a;
        start_cond();
        send_byte({dev, 1'b0}, a[0]);
        send_byte(p, a[1]);
        send_byte(d0, a[2]);
        a[3] = 1'b1;
        if (two) begin
            send_byte(d1, a[3]);
        end
        stop_cond();
        ok = &a;
    endtask
    // a refusal on the ninth clock ends the read, an answer asks for one more byte
    task automatic read_reg(input fmpg_byte_t p, input logic two, output fmpg_byte_t d,
                            output fmpg_byte_t d2, output logic ok);
        logic [2:0] a;
        logic [8:0] r;
        logic [8:0] r2;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a[0]);
        send_byte(p, a[1]);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, a[2]);
        for (int i = 8; i >= 0; i--) begin
            bit_clk((i != 0) | ~two, r[i]);
        end
        if (two) begin
            for (int i = 8; i >= 0; i--) begin
                bit_clk(1'b1, r2[i]);
            end
        end
        stop_cond();
        d = r[8:1];
        d2 = r2[8:1];
        ok = &a;
    endtask
endmodule // fmpg_host
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------
// bench
// ------------
module testbench
    import fmpg_pkg::*;
;
    localparam logic [6:0] DEV = 7'h5e; // arbitrary value
    localparam fmpg_byte_t FM0 = 8'hb5;
    localparam fmpg_byte_t SA0 = 8'h5a;
    localparam fmpg_byte_t SB0 = 8'hc3;
    logic        core_clk   = 1'b0;
    logic        reset      = 1'b1;
    logic        sclPin;
    logic        sdaPin;
    logic        sdaOe;
    logic        sdaOut;
    logic [15:0] pgVec      = 16'hffff;
    logic [4:0]  faultVec   = 5'h00;
    logic        outOne;
    logic        shutdown;
    int          num_errors = 0;
    int          cmp_count  = 0;
    always #5 core_clk = ~core_clk;
    fmpg_host #(.DEV_ADDR(DEV)) host (.core_clk, .sclPin, .sdaPin, .sdaOut, .sdaOe);
    fmpg_regs #(.DEV_ADDR(DEV), .FAULT_MASK_B(FM0), .SELECT_A(SA0), .SELECT_B(SB0)) uut (
        .core_clk, .reset, .sclPin, .sdaPin, .sdaOut, .sdaOe, .ctrlPin(pgVec[7:4]),
        .buckPg(pgVec[13:8]), .auxLdo2Pg(pgVec[15]), .switchA1Pg(pgVec[14]),
        .terminationPg(pgVec[3]), .sharedRailPg(pgVec[2]), .switchB1Pg(pgVec[1]),
        .auxLdo3Pg(pgVec[0]), .auxLdo1Fault(faultVec[4]), .terminationFault(faultVec[3]),
        .switchB2Fault(faultVec[2]), .switchB1Fault(faultVec[1]), .auxLdo3Fault(faultVec[0]),
        .generalOutputOne(outOne), .shutdownRequest(shutdown)
    );
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input fmpg_byte_t p, input fmpg_byte_t d0, input fmpg_byte_t d1,
                      input logic two);
        logic ok;
        host.write_reg(DEV, p, d0, d1, two, ok);
        check("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic rd(input fmpg_byte_t p, input fmpg_byte_t exp);
        fmpg_byte_t d;
        fmpg_byte_t d2;
        logic       ok;
        host.read_reg(p, 1'b0, d, d2, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check("read data", exp, d);
    endtask
    // control pins pass a 4-cycle sync before the tree, 6 leaves margin
    task automatic outs(input logic expOne, input logic expDown);
        host.hcyc(6);
        check("output one", {7'h00, expOne}, {7'h00, outOne});
        check("shutdown", {7'h00, expDown}, {7'h00, shutdown});
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #500_000;
        num_errors++;
        $display("BAD watchdog expected finish seen hang");
        end_sim();
    end
    initial begin
        logic [15:0] inc;
        logic        ok;
        fmpg_byte_t  rdA, rdB;
        repeat (16) @(posedge core_clk);
        #1;
        reset = 1'b0;
        host.hcyc(8);
        rd(8'ha3, FM0);
        rd(8'ha4, SA0);
        rd(8'ha5, SB0);
        rd(8'h10, 8'h00);
        wr(8'ha3, 8'h2a, 8'h00, 1'b0);
        rd(8'ha3, {FM0[7], 7'h2a});
        host.write_reg(DEV ^ 7'h01, 8'ha4, 8'h00, 8'h00, 1'b1, ok);
        check("foreign ack", 8'h00, {7'h00, ok});
        rd(8'ha4, SA0);
        host.read_reg(8'ha4, 1'b1, rdA, rdB, ok);
        check("burst ack", 8'h01, {7'h00, ok});
        check("burst first", SA0, rdA);
        check("burst second", SB0, rdB);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            // only rail i unmasked, bit 5 kept one and bit 6 zero
            wr(8'ha3, 8'h3f & ~(8'h01 << i), 8'h00, 1'b0);
            faultVec = ~(5'h01 << i);
            outs(1'b1, 1'b0);
            faultVec = 5'h01 << i;
            outs(1'b1, 1'b1);
        end
        faultVec = 5'h00;
        $display("test fault masks done");
        for (int i = 0; i < 16; i++) begin
            // one source included, driven bad then good, every other one driven the opposite way
            inc = 16'h0001 << i;
            wr(8'ha4, ~inc[15:8], ~inc[7:0], 1'b1);
            pgVec = ~inc;
            outs(1'b0, 1'b0);
            pgVec = inc;
            outs(1'b1, 1'b0);
        end
        rd(8'ha4, 8'h7f);
        rd(8'ha5, 8'hff);
        wr(8'ha4, 8'h00, 8'h00, 1'b1);
        pgVec = 16'hffff;
        outs(1'b1, 1'b0);
        pgVec = 16'hffef;
        outs(1'b0, 1'b0);
        $display("test power-good tree done");
        reset = 1'b1;
        host.hcyc(4);
        reset = 1'b0;
        host.hcyc(8);
        rd(8'ha4, SA0);
        pgVec = 16'hffff;
        outs(1'b1, 1'b0);
        pgVec = 16'hffef;
        outs(1'b0, 1'b0);
        $display("test second reset done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
